// >>> inc/iscw_pkg.sv
// Package: shared constants and types for the isolated serial converter and watchdog
package iscw_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CTRL_STAGES = 6;
  localparam int unsigned STAGE_W = 8;
  localparam int unsigned CTRL_W = CTRL_STAGES * STAGE_W;
  localparam int unsigned STAT_W = 16;
  localparam int unsigned BURST_BITS = 24;
  localparam int unsigned BLOCKS = 5;
  localparam int unsigned ATTEMPTS = 3;
  localparam int unsigned PRELOAD_BURSTS = 2;
  localparam int unsigned READ_BURSTS = 3;
  localparam int unsigned STROBE_COUNT = 2;
  // Times in milliseconds, as printed
  localparam int unsigned T_TRIP_DELAY_MS = 47;
  localparam int unsigned T_POWERON_HOLD_MS = 80;
  localparam int unsigned T_VERIFY_MS = 470;
  localparam int unsigned T_PANEL_MS = 100;
  localparam int unsigned T_ALIVE_MS = 8;
  localparam int unsigned T_XFER_MS = 40;
  localparam int unsigned T_RETRIG_MS = 18;
  localparam int unsigned T_GATE_MS = 470;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  // Default cycle counts; the modules expose them as parameters
  localparam int unsigned CYC_TRIP_DELAY = T_TRIP_DELAY_MS * CYC_PER_MS;
  localparam int unsigned CYC_POWERON_HOLD = T_POWERON_HOLD_MS * CYC_PER_MS;
  localparam int unsigned CYC_VERIFY = T_VERIFY_MS * CYC_PER_MS;
  localparam int unsigned CYC_PANEL = T_PANEL_MS * CYC_PER_MS;
  localparam int unsigned CYC_ALIVE = T_ALIVE_MS * CYC_PER_MS;
  localparam int unsigned CYC_XFER = T_XFER_MS * CYC_PER_MS;
  localparam int unsigned CYC_RETRIG = T_RETRIG_MS * CYC_PER_MS;
  localparam int unsigned CYC_GATE = T_GATE_MS * CYC_PER_MS;
  localparam int unsigned TMR_W = 32;
  localparam int unsigned LINK_DIV = 16;
  localparam int unsigned DIV_W = 8;
  localparam int unsigned BIT_W = 5;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned FAIL_BIT = 15;
  typedef logic [CTRL_W-1:0] iscw_ctrl_t;
  typedef logic [STAT_W-1:0] iscw_stat_t;
endpackage

// >>> inc/iscw_link_if.sv
// Interface: isolated serial link between host adaptor and converter
`timescale 1ns/1ps
interface iscw_link_if;
  logic link_clk;
  logic ser_in;
  logic ser_out;
  logic strobe;
  logic alive_pulse;
  logic alive_gate_trigger;
  modport host (output link_clk, output ser_in, input ser_out, output strobe,
    output alive_pulse, output alive_gate_trigger);
  modport dev (input link_clk, input ser_in, output ser_out, input strobe,
    input alive_pulse, input alive_gate_trigger);
endinterface

// >>> src/iscw_retrig_timer.sv
// Retriggerable timer counting system clocks
`timescale 1ns/1ps
module iscw_retrig_timer #(
  parameter int unsigned DUR = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic trig,
  input wire logic hold,
  output logic running
);
  import iscw_pkg::*;
  logic [TMR_W-1:0] count;
  wire logic at_end = (count == TMR_W'(DUR));
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      running <= 1'b0;
    end else if (ce) begin
      if (hold) begin
        count <= '0;
        running <= 1'b0;
      end else if (trig) begin
        count <= '0;
        running <= 1'b1;
      end else if (running) begin
        count <= count + TMR_W'(1);
        if (at_end) begin
          running <= 1'b0;
        end
      end
    end
  end
endmodule // iscw_retrig_timer

// >>> src/iscw_device.sv
// Isolated side: serial/parallel converter and safety watchdog
`timescale 1ns/1ps
module iscw_device #(
  parameter int unsigned CYC_TRIP_DELAY_P = iscw_pkg::CYC_TRIP_DELAY,
  parameter int unsigned CYC_POWERON_P = iscw_pkg::CYC_POWERON_HOLD,
  parameter int unsigned CYC_VERIFY_P = iscw_pkg::CYC_VERIFY,
  parameter int unsigned CYC_PANEL_P = iscw_pkg::CYC_PANEL,
  parameter int unsigned CYC_RETRIG_P = iscw_pkg::CYC_RETRIG,
  parameter int unsigned CYC_GATE_P = iscw_pkg::CYC_GATE
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  iscw_link_if.dev link,
  input wire logic panel_reset,
  input wire iscw_pkg::iscw_stat_t status_in,
  output iscw_pkg::iscw_ctrl_t ctrl_out,
  output iscw_pkg::iscw_ctrl_t ctrl_oe,
  output logic safety_trip,
  output logic safety_trip_n,
  output logic delayed_safety_trip,
  output logic delayed_trip_short
);
  import iscw_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0] s_clk, s_din, s_stb, s_alive, s_gate, s_panel;
  logic clk_prev, stb_prev, alive_prev, gate_prev;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_clk <= '0;
      s_din <= '0;
      s_stb <= '0;
      s_alive <= '0;
      s_gate <= '0;
      s_panel <= '0;
      clk_prev <= 1'b0;
      stb_prev <= 1'b0;
      alive_prev <= 1'b0;
      gate_prev <= 1'b0;
    end else if (ce) begin
      s_clk <= {s_clk[0], link.link_clk};
      s_din <= {s_din[0], link.ser_in};
      s_stb <= {s_stb[0], link.strobe};
      s_alive <= {s_alive[0], link.alive_pulse};
      s_gate <= {s_gate[0], link.alive_gate_trigger};
      s_panel <= {s_panel[0], panel_reset};
      clk_prev <= s_clk[1];
      stb_prev <= s_stb[1];
      alive_prev <= s_alive[1];
      gate_prev <= s_gate[1];
    end
  end
  // Inverted clock rises where the link clock falls, mid-bit, so data has settled
  wire logic shift_evt = clk_prev & ~s_clk[1];
  wire logic stb_rise = s_stb[1] & ~stb_prev;
  wire logic alive_rise = s_alive[1] & ~alive_prev;
  wire logic gate_rise = s_gate[1] & ~gate_prev;
  wire logic strobe_lvl = s_stb[1];
  wire logic panel_lvl = s_panel[1];
  ////////////////////////////////////////////////////////////////////////////
  // Shift chain and latches
  iscw_ctrl_t ctrl_shift;
  iscw_ctrl_t ctrl_latch;
  iscw_stat_t stat_shift;
  logic ser_out_q;
  wire iscw_ctrl_t next_ctrl_shift = {ctrl_shift[CTRL_W-2:0], s_din[1]};
  wire iscw_stat_t next_stat_shift = {stat_shift[STAT_W-2:0], ctrl_shift[CTRL_W-1]};
  // Fail bit carries the inverted trip level, held high while the start-up window is open
  wire iscw_stat_t stat_capture = {safety_trip_n, status_in[FAIL_BIT-1:0]};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_shift <= '0;
      stat_shift <= '0;
      ctrl_latch <= '0;
      ser_out_q <= 1'b0;
    end else if (ce) begin
      if (strobe_lvl) begin
        ctrl_latch <= ctrl_shift;
        stat_shift <= stat_capture;
      end else if (shift_evt) begin
        ctrl_shift <= next_ctrl_shift;
        stat_shift <= next_stat_shift;
      end
      // Without shift edges or a strobe the registers keep their contents
      ser_out_q <= stat_shift[STAT_W-1];
    end
  end
  assign link.ser_out = ser_out_q;
  ////////////////////////////////////////////////////////////////////////////
  // Power-on and panel-reset windows
  logic [TMR_W-1:0] por_cnt, verify_cnt, panel_cnt;
  logic [1:0] stb_seen;
  wire logic por_done = (por_cnt == TMR_W'(CYC_POWERON_P));
  wire logic verify_open = (verify_cnt != TMR_W'(CYC_VERIFY_P));
  wire logic panel_open = (panel_cnt != TMR_W'(CYC_PANEL_P));
  wire logic armed = (stb_seen == 2'(STROBE_COUNT));
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      por_cnt <= '0;
      verify_cnt <= '0;
      panel_cnt <= TMR_W'(CYC_PANEL_P);
      stb_seen <= '0;
    end else if (ce) begin
      if (!por_done) begin
        por_cnt <= por_cnt + TMR_W'(1);
      end else if (stb_rise && !armed) begin
        stb_seen <= stb_seen + 2'd1;
      end
      if (verify_open) begin
        verify_cnt <= verify_cnt + TMR_W'(1);
      end
      if (panel_lvl) begin
        panel_cnt <= '0;
      end else if (panel_open) begin
        panel_cnt <= panel_cnt + TMR_W'(1);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Alive gating and retrigger timer
  logic gate_on, alive_on;
  iscw_retrig_timer #(.DUR(CYC_GATE_P)) u_gate (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .trig(gate_rise),
    .hold(1'b0),
    .running(gate_on)
  );
  wire logic alive_ok = alive_rise & gate_on;
  iscw_retrig_timer #(.DUR(CYC_RETRIG_P)) u_alive (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .trig(alive_ok),
    .hold(~armed),
    .running(alive_on)
  );
  wire logic fault = ~alive_on;
  // Reset windows only allow clearing, never override a live fault
  wire logic clear_win = verify_open | panel_open | panel_lvl;
  // Fault wins over a clearing window; the fail bit takes the inverse of the same value once the start-up window has closed
  wire logic next_safety_trip = fault | (safety_trip & ~clear_win);
  ////////////////////////////////////////////////////////////////////////////
  // Trip flip-flops
  logic [TMR_W-1:0] del_cnt;
  wire logic del_done = (del_cnt == TMR_W'(CYC_TRIP_DELAY_P));
  logic del_trip;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      safety_trip <= 1'b1;
      safety_trip_n <= 1'b1;
      del_trip <= 1'b1;
      del_cnt <= '0;
    end else if (ce) begin
      safety_trip <= next_safety_trip;
      // Fail report masked while the start-up window is open
      safety_trip_n <= verify_open ? 1'b1 : ~next_safety_trip;
      if (!safety_trip) begin
        del_cnt <= '0;
      end else if (!del_done) begin
        del_cnt <= del_cnt + TMR_W'(1);
      end
      if (!armed) begin
        del_trip <= 1'b1;
      end else if (safety_trip && del_done) begin
        del_trip <= 1'b1;
      end else if (!safety_trip && clear_win) begin
        del_trip <= 1'b0;
      end else if (!safety_trip && verify_open) begin
        del_trip <= 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      delayed_safety_trip <= 1'b1;
      delayed_trip_short <= 1'b1;
      ctrl_out <= '0;
      ctrl_oe <= '0;
    end else if (ce) begin
      delayed_safety_trip <= del_trip;
      delayed_trip_short <= del_trip;
      ctrl_out <= ctrl_latch;
      ctrl_oe <= {CTRL_W{~del_trip}};
    end
  end
endmodule // iscw_device

// >>> src/iscw_host.sv
// Host side: serial adaptor sequencer with read-back check and alive pulses
`timescale 1ns/1ps
module iscw_host #(
  parameter int unsigned CYC_ALIVE_P = iscw_pkg::CYC_ALIVE,
  parameter int unsigned CYC_XFER_P = iscw_pkg::CYC_XFER
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  iscw_link_if.host link,
  input wire iscw_pkg::iscw_ctrl_t ctrl_word,
  output iscw_pkg::iscw_stat_t status_word,
  output logic verify_fail,
  output logic busy
);
  import iscw_pkg::*;
  typedef enum logic [2:0] {H_IDLE, H_SHIFT, H_STROBE, H_CHECK, H_GAP} iscw_hst_t;
  iscw_hst_t state;
  logic [DIV_W-1:0] div;
  logic [BIT_W-1:0] bitn;
  logic [CNT_W-1:0] burst, tries;
  logic [TMR_W-1:0] xfer_cnt, alive_cnt;
  // Read bursts carry status, the control word and a trailing dummy byte
  localparam int unsigned READ_W = (BLOCKS - PRELOAD_BURSTS) * BURST_BITS;
  localparam int unsigned PAD_W = READ_W - CTRL_W - STAT_W;
  logic [CTRL_W+STAT_W-1:0] tx;
  logic [READ_W-1:0] rx;
  logic [1:0] s_rx;
  logic lclk, stb, ok, alive, gate;
  wire logic half = (div == DIV_W'(LINK_DIV/2 - 1));
  wire logic bit_end = (bitn == BIT_W'(BURST_BITS - 1));
  wire logic last_burst = (burst == CNT_W'(BLOCKS - 1));
  wire logic match = (rx[PAD_W +: CTRL_W] == ctrl_word);
  // First bit is on the line before the first clock, so that rising edge must not shift
  wire logic first_bit = (bitn == '0) && (burst == '0);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= H_IDLE;
      div <= '0;
      bitn <= '0;
      burst <= '0;
      tries <= '0;
      xfer_cnt <= '0;
      alive_cnt <= '0;
      tx <= '0;
      rx <= '0;
      s_rx <= '0;
      lclk <= 1'b0;
      stb <= 1'b0;
      ok <= 1'b0;
      alive <= 1'b0;
      gate <= 1'b0;
      status_word <= '0;
      verify_fail <= 1'b0;
      busy <= 1'b0;
    end else if (ce) begin
      s_rx <= {s_rx[0], link.ser_out};
      alive <= 1'b0;
      gate <= 1'b0;
      xfer_cnt <= (xfer_cnt == TMR_W'(CYC_XFER_P - 1)) ? '0 : xfer_cnt + TMR_W'(1);
      alive_cnt <= (alive_cnt == TMR_W'(CYC_ALIVE_P - 1)) ? '0 : alive_cnt + TMR_W'(1);
      // Alive pulses stop after repeated mismatch so the watchdog trips
      if (alive_cnt == '0 && ok && !verify_fail) begin
        alive <= 1'b1;
      end
      unique case (state)
        H_IDLE: begin
          if (xfer_cnt == '0) begin
            tx <= {ctrl_word, {STAT_W{1'b0}}};
            burst <= '0;
            busy <= 1'b1;
            state <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          div <= half ? '0 : div + DIV_W'(1);
          if (half) begin
            lclk <= ~lclk;
            if (lclk) begin
              rx <= {rx[READ_W-2:0], s_rx[1]};
              bitn <= bit_end ? '0 : bitn + BIT_W'(1);
              if (bit_end) begin
                burst <= burst + CNT_W'(1);
                if (burst == CNT_W'(PRELOAD_BURSTS - 1)) begin
                  state <= H_STROBE;
                end else if (last_burst) begin
                  state <= H_CHECK;
                end
              end
            end else if (!first_bit) begin
              tx <= {tx[CTRL_W+STAT_W-2:0], 1'b0};
            end
          end
        end
        H_STROBE: begin
          stb <= ~stb;
          if (stb) begin
            state <= H_SHIFT;
          end
        end
        H_CHECK: begin
          status_word <= rx[READ_W-1 -: STAT_W];
          busy <= 1'b0;
          if (match) begin
            ok <= 1'b1;
            tries <= '0;
            gate <= 1'b1;
            state <= H_IDLE;
          end else if (tries == CNT_W'(ATTEMPTS - 1)) begin
            verify_fail <= 1'b1;
            state <= H_GAP;
          end else begin
            tries <= tries + CNT_W'(1);
            state <= H_IDLE;
          end
        end
        H_GAP: begin
          state <= H_IDLE;
        end
      endcase
    end
  end
  assign link.link_clk = lclk;
  assign link.ser_in = tx[CTRL_W+STAT_W-1];
  assign link.strobe = stb;
  assign link.alive_pulse = alive;
  assign link.alive_gate_trigger = gate;
endmodule // iscw_host

// >>> test/iscw_link_properties.sv
// Checker: link framing and watchdog timing seen at the two joined ends
`timescale 1ns/1ps
module iscw_link_properties #(
  parameter int unsigned CYC_TRIP_DELAY_P = 40,
  parameter int unsigned CYC_POWERON_P = 80,
  parameter int unsigned CYC_VERIFY_P = 2000,
  parameter int unsigned CYC_RETRIG_P = 400,
  parameter int unsigned CYC_GATE_P = 4000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic strobe,
  input wire logic alive_pulse,
  input wire logic alive_gate_trigger,
  input wire iscw_pkg::iscw_ctrl_t ctrl_out,
  input wire iscw_pkg::iscw_ctrl_t ctrl_oe,
  input wire logic safety_trip,
  input wire logic safety_trip_n,
  input wire logic delayed_safety_trip,
  input wire logic delayed_trip_short
);
  import iscw_pkg::*;
  // Window allows for the device's input synchroniser
  localparam int TD_LO = CYC_TRIP_DELAY_P - 9;
  localparam int TD_HI = CYC_TRIP_DELAY_P - 3;
  logic [31:0] up_cnt, since_stb, since_alive, since_gate;
  logic [7:0] edges;
  logic seen_stb;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      up_cnt <= '0;
      since_stb <= '0;
      since_alive <= '0;
      since_gate <= '0;
      edges <= '0;
      seen_stb <= 1'b0;
    end else begin
      up_cnt <= up_cnt + 1;
      since_stb <= strobe ? '0 : since_stb + 1;
      since_alive <= alive_pulse ? '0 : since_alive + 1;
      since_gate <= alive_gate_trigger ? '0 : since_gate + 1;
      edges <= $rose(strobe) ? '0 : edges + 8'($rose(link_clk));
      seen_stb <= seen_stb | strobe;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence trip_rise;
    $rose(safety_trip) && !delayed_safety_trip;
  endsequence
  strobe_pulse_a: assert property ($rose(strobe) |=> !strobe)
    else $error("strobe wider than one cycle");
  strobe_gap_a: assert property (strobe |-> !link_clk)
    else $error("strobe inside a burst");
  burst_count_a: assert property ($rose(strobe) |->
    edges == (seen_stb ? 8'(BURST_BITS * 5) : 8'(BURST_BITS * 2)))
    else $error("wrong shift clock count before strobe");
  ctrl_hold_a: assert property ($changed(ctrl_out) |-> since_stb < 10)
    else $error("control outputs changed away from a strobe");
  trip_delay_a: assert property (trip_rise |->
    (!delayed_safety_trip) [*8] ##[TD_LO:TD_HI] delayed_safety_trip)
    else $error("delayed trip off time");
  trip_pair_a: assert property (delayed_trip_short == delayed_safety_trip)
    else $error("delayed trip outputs differ");
  oe_off_a: assert property (delayed_safety_trip && $past(delayed_safety_trip) |->
    ctrl_oe == '0)
    else $error("outputs driven during delayed trip");
  fail_flag_a: assert property (!safety_trip_n |-> safety_trip)
    else $error("failure reported without trip");
  fail_hold_a: assert property (up_cnt < CYC_VERIFY_P - 4 |-> safety_trip_n)
    else $error("failure reported inside start window");
  start_hold_a: assert property (up_cnt < CYC_POWERON_P |->
    delayed_safety_trip && safety_trip)
    else $error("trips released during power-on hold");
  alive_expiry_a: assert property (since_alive > CYC_RETRIG_P + 8 |-> safety_trip)
    else $error("no trip after missing alive pulses");
  gate_expiry_a: assert property (
    since_gate > CYC_GATE_P + CYC_RETRIG_P + 16 |-> safety_trip)
    else $error("no trip after gate trigger loss");
endmodule // iscw_link_properties

// >>> test/isolated_serial_converter_watchdog_tb.sv
// Testbench: host and device joined over the link, normal transfers and watchdog faults
`timescale 1ns/1ps
module isolated_serial_converter_watchdog_tb;
  import iscw_pkg::*;
  localparam int TD = 40;
  localparam int PON = 80;
  localparam int VER = 12000;
  localparam int PNL = 4000;
  localparam int RTG = 400;
  localparam int GATE = 6000;
  localparam int XFER = 2500;
  logic sys_clk, rst, ce_dev, ce_host, panel_reset;
  iscw_stat_t status_in, status_word;
  iscw_ctrl_t ctrl_word, ctrl_out, ctrl_oe;
  logic safety_trip, safety_trip_n, delayed_safety_trip, delayed_trip_short, verify_fail, busy;
  int miscompares = 0;
  int comparisons = 0;
  iscw_ctrl_t words [3] = '{48'hA5C3_0F1E_9B27, 48'hFFFF_FFFF_FFFF, 48'h8000_0000_0001};
  iscw_stat_t stats [3] = '{16'h5A3C, 16'h7FFF, 16'h0001};
  iscw_link_if link_i ();
  iscw_device #(.CYC_TRIP_DELAY_P(TD), .CYC_POWERON_P(PON), .CYC_VERIFY_P(VER),
    .CYC_PANEL_P(PNL), .CYC_RETRIG_P(RTG), .CYC_GATE_P(GATE)) iscw_device_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce_dev), .link(link_i), .panel_reset(panel_reset),
    .status_in(status_in), .ctrl_out(ctrl_out), .ctrl_oe(ctrl_oe), .safety_trip(safety_trip),
    .safety_trip_n(safety_trip_n), .delayed_safety_trip(delayed_safety_trip),
    .delayed_trip_short(delayed_trip_short));
  iscw_host #(.CYC_ALIVE_P(100), .CYC_XFER_P(XFER)) iscw_host_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce_host), .link(link_i), .ctrl_word(ctrl_word),
    .status_word(status_word), .verify_fail(verify_fail), .busy(busy));
  iscw_link_properties #(.CYC_TRIP_DELAY_P(TD), .CYC_POWERON_P(PON), .CYC_VERIFY_P(VER),
    .CYC_RETRIG_P(RTG), .CYC_GATE_P(GATE)) iscw_link_properties_inst (
    .sys_clk(sys_clk), .rst(rst), .link_clk(link_i.link_clk), .strobe(link_i.strobe),
    .alive_pulse(link_i.alive_pulse), .alive_gate_trigger(link_i.alive_gate_trigger),
    .ctrl_out(ctrl_out), .ctrl_oe(ctrl_oe), .safety_trip(safety_trip),
    .safety_trip_n(safety_trip_n), .delayed_safety_trip(delayed_safety_trip),
    .delayed_trip_short(delayed_trip_short));
  ////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check_vec(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  function automatic logic cond(input int sel);
    case (sel)
      0: return ctrl_out === ctrl_word;
      1: return safety_trip === 1'b0;
      2: return safety_trip === 1'b1;
      3: return delayed_safety_trip === 1'b1;
      5: return busy === 1'b0;
      default: return delayed_safety_trip === 1'b0;
    endcase
  endfunction
  // Bounded wait; a hang ends the run instead of stalling it
  task automatic wait_until(input int sel, input int lim);
    int n;
    n = 0;
    while (!cond(sel) && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (!cond(sel)) begin
      miscompares++;
      $display("ERROR %0t: wait %0d timed out", $time, sel);
      close_out();
    end
  endtask
  task automatic press_panel();
    @(posedge sys_clk);
    panel_reset <= 1'b1;
    repeat (20) @(posedge sys_clk);
    panel_reset <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    $display("ERROR %0t: run limit reached", $time);
    close_out();
  end
  initial begin
    rst = 1'b1;
    ce_dev = 1'b1;
    ce_host = 1'b1;
    panel_reset = 1'b0;
    ctrl_word = words[0];
    status_in = stats[0];
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check_flag(safety_trip, 1'b1);
    check_flag(delayed_trip_short, 1'b1);
    check_vec(ctrl_oe, '0);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      ctrl_word <= words[i];
      status_in <= stats[i];
      @(posedge sys_clk);
      wait_until(0, 4 * XFER);
      wait_until(1, VER);
      wait_until(4, XFER);
      repeat (2 * XFER) @(posedge sys_clk);
      @(negedge sys_clk);
      check_vec(ctrl_out, words[i]);
      check_vec(ctrl_oe, '1);
      check_vec(48'(status_word[14:0]), 48'(stats[i][14:0]));
      check_flag(status_word[15], 1'b1);
      check_flag(verify_fail, 1'b0);
    end
    // Freeze the host between transfers so no strobe is left standing
    wait_until(5, XFER);
    @(posedge sys_clk);
    ce_host <= 1'b0;
    wait_until(2, RTG + 100);
    wait_until(3, TD + 20);
    repeat (4) @(negedge sys_clk);
    check_vec(ctrl_oe, '0);
    check_flag(safety_trip_n, 1'b0);
    press_panel();
    repeat (PNL + GATE) @(negedge sys_clk);
    check_flag(safety_trip, 1'b1);
    @(posedge sys_clk);
    ce_host <= 1'b1;
    repeat (2 * XFER) @(negedge sys_clk);
    check_flag(status_word[15], 1'b0);
    check_flag(safety_trip, 1'b1);
    press_panel();
    wait_until(1, PNL);
    wait_until(4, 2 * XFER);
    @(negedge sys_clk);
    check_vec(ctrl_oe, '1);
    close_out();
  end
endmodule // isolated_serial_converter_watchdog_tb
